// ---- bench/bus_partner.sv ----
// behavioural model of the observed processor bus
`default_nettype none
module bus_partner (
  input wire logic core_clk,
  output logic bus_strobe,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_data,
  output logic bus_read,
  output logic instruction_start_flag,
  output logic [5:0] user_probe_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    bus_strobe = 1'b0;
    bus_addr = 16'h0000;
    bus_data = 8'h00;
    bus_read = 1'b1;
    instruction_start_flag = 1'b0;
    user_probe_inputs = 6'h00;
  end
  // one bus cycle; released lines show the inverse of the last value
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic r,
    input logic s, input logic [5:0] p);
    @(posedge core_clk);
    bus_strobe <= 1'b1;
    // keeps stacking out of the low end of the program region
    bus_addr <= (!r && a inside {[16'hC000:16'hC014]}) ? 16'h00FF : a;
    bus_data <= d;
    bus_read <= r;
    instruction_start_flag <= s;
    user_probe_inputs <= p;
    @(posedge core_clk);
    bus_strobe <= 1'b0;
    bus_addr <= ~a;
    bus_data <= ~d;
    bus_read <= ~r;
    instruction_start_flag <= ~s;
    user_probe_inputs <= ~p;
  endtask
endmodule // bus_partner
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the bus trace fault capture block
`default_nettype none
module tb
  import trace_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic user_running = 1'b0;
  wire logic hreadyout, hresp, nmi, bus_strobe, bus_read, instruction_start_flag;
  wire logic [31:0] hrdata;
  wire logic [15:0] bus_addr;
  wire logic [7:0] bus_data;
  wire logic [5:0] user_probe_inputs;
  int failures = 0;
  int total_checks = 0;
  int seed = 32'h3ABC;
  int trig, cur;
  logic [31:0] recs[$];
  logic [31:0] v;
  logic cap = 1'b0;

  always #10 core_clk = ~core_clk;

  bus_trace_fault_capture u_dut (
    .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_strobe(bus_strobe),
    .bus_addr(bus_addr), .bus_data(bus_data), .bus_read(bus_read),
    .instruction_start_flag(instruction_start_flag),
    .user_probe_inputs(user_probe_inputs), .user_running(user_running), .nmi(nmi));

  bus_partner u_bus (
    .core_clk(core_clk), .bus_strobe(bus_strobe), .bus_addr(bus_addr),
    .bus_data(bus_data), .bus_read(bus_read),
    .instruction_start_flag(instruction_start_flag),
    .user_probe_inputs(user_probe_inputs));

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++k < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1 && ++k < 40);
    v = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (k >= 40)
    begin
      failures++;
      conclude();
    end
  endtask

  task automatic stat(input logic [31:0] e, input logic [31:0] m);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status", e, v & m);
  endtask

  task automatic off();
    ahb(1'b0, OFS_OFFSET, 32'h0);
    chk("offset", 32'(cur - trig), v);
  endtask

  task automatic idle();
    for (int k = 0; k < 20000; k++)
    begin
      ahb(1'b0, OFS_STATUS, 32'h0);
      if (v[ST_BUSY] === 1'b0)
        return;
    end
    failures++;
    conclude();
  endtask

  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic r, input logic s);
    logic [5:0] p;
    p = 6'($random(seed));
    u_bus.cycle(a, d, r, s, p);
    if (cap)
      recs.push_back({a, d, p, r, s});
    if (recs.size() > DEPTH)
      void'(recs.pop_front());
  endtask

  // fetch, operand reads, then one data cycle (a program-region write when wf)
  task automatic instr(input logic [15:0] pc, input logic wf);
    int n;
    n = 1 + ($random(seed) & 3);
    cyc(pc, 8'($random(seed)), 1'b1, 1'b1);
    for (int k = 1; k < n; k++)
      cyc(pc + 16'(k), 8'($random(seed)), 1'b1, 1'b0);
    cyc(wf ? (16'hE000 | 16'($random(seed))) : (16'($random(seed)) & 16'h0FFF),
      8'($random(seed)), wf ? 1'b0 : 1'($random(seed)), 1'b0);
  endtask

  function automatic int find_exp(input int n, input logic [3:0] en,
    input logic [31:0] ac, input logic [31:0] dc);
    int c;
    logic [31:0] r;
    logic ok;
    c = 0;
    for (int i = cur + (n > 0 ? 1 : -1); i >= 0 && i < recs.size(); i += (n > 0 ? 1 : -1))
    begin
      r = recs[i];
      ok = !(en[0] || en[1]) || ((r[31:16] ^ ac[15:0]) & ac[31:16]) == 16'h0;
      ok &= !en[1] || r[0];
      ok &= !en[2] || ((r[15:8] ^ dc[7:0]) & dc[15:8]) == 8'h0;
      ok &= !en[3] || ((r[7:0] ^ dc[23:16]) & dc[31:24]) == 8'h0;
      c += ok;
      if (c == (n > 0 ? n : -n))
      begin
        while (i > 0 && recs[i][0] !== 1'b1)
          i--;
        return i;
      end
    end
    return -1;
  endfunction

  task automatic search(input logic [3:0] en, input logic [31:0] ac, input logic [31:0] dc,
    input int n);
    int e;
    e = find_exp(n, en, ac, dc);
    ahb(1'b1, OFS_ACRIT, ac);
    ahb(1'b1, OFS_DCRIT, dc);
    ahb(1'b1, OFS_SEARCH, {1'b0, 15'(n), 12'h0, en});
    idle();
    chk("flags", (e >= 0) ? 32'h10 : 32'h20, v & 32'h30);
    ahb(1'b0, OFS_SEARCH, 32'h0);
    chk("search", {1'b0, 15'(n), 12'h0, en}, v);
    if (e >= 0)
      cur = e;
    off();
  endtask

  task automatic run(input int mode, input int ni);
    int i;
    ahb(1'b1, OFS_CTRL, 32'h1);
    recs.delete();
    cap = 1'b1;
    stat(32'h5, 32'h3FFF00FF);
    ahb(1'b0, OFS_OFFSET, 32'h0);
    chk("offset", 32'h0, v);
    user_running <= 1'b1;
    for (i = 0; i < ni; i++)
      instr(16'hC100 | (16'($random(seed)) & 16'h3EF0), 1'b0);
    chk("nmi", 32'h0, {31'h0, nmi});
    if (mode == 1)
      instr(16'hD000, 1'b1);
    if (mode == 2)
      cyc(16'h1000, 8'h01, 1'b1, 1'b1);
    cap = 1'b0;
    if (mode != 0)
    begin
      @(posedge core_clk);
      #1;
      chk("nmi", 32'h1, {31'h0, nmi});
      cyc(16'h0800, 8'h00, 1'b1, 1'b1);
      i = recs.size() - 2;
      while (recs[i][0] !== 1'b1)
        i--;
      trig = i;
      cur = i;
      off();
      stat({2'h0, 14'(recs.size()), 16'h0002}, 32'h3FFF00FF);
    end
    @(posedge core_clk);
    user_running <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("nmi", 32'h0, {31'h0, nmi});
    if (mode == 0)
      stat(32'h4, 32'h3FFF00FF);
  endtask

  initial
  begin
    logic [31:0] r, c;
    logic [3:0] en;
    int t;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, v);
    stat(32'h4, 32'h3FFF00FF);
    ahb(1'b1, OFS_SEARCH, 32'h1);
    idle();
    stat(32'h40, 32'hF0);
    run(0, 20);
    ahb(1'b1, OFS_OFFSET, 32'h5);
    stat(32'h40, 32'hF0);
    run(1, 40);
    for (int i = 0; i < 24; i++)
    begin
      r = recs[($random(seed) & 32'hFFFF) % recs.size()];
      en = 4'($random(seed));
      if (en[0])
        en[1] = 1'b0;
      c = (i % 4 == 0) ? 32'hFFFF_FFFF : $random(seed);
      search(en, {c[15:0], r[31:16]}, {c[31:24], r[7:0], c[23:16], r[15:8]},
        (i % 2) ? 1 + i % 3 : -1 - i % 3);
    end
    search(4'h1, 32'hFFFF_B000, 32'h0, 1);
    t = (cur == 0) ? 1 : 0;
    ahb(1'b1, OFS_OFFSET, 32'(cur - trig) & 32'h7FFF);
    stat(32'h80, 32'hF0);
    ahb(1'b1, OFS_OFFSET, 32'(t - trig) & 32'h7FFF);
    cur = t;
    off();
    ahb(1'b1, OFS_OFFSET, 32'(recs.size() - trig) & 32'h7FFF);
    stat(32'h20, 32'hF0);
    off();
    run(2, 30);
    search(4'h2, 32'hFFFF_1000, 32'h0, 1);
    run(1, 2600);
    search(4'h0, 32'h0, 32'h0, -3);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    stat(32'h4, 32'h3FFF00FF);
    conclude();
  end

  initial
  begin
    #1800000;
    failures++;
    conclude();
  end
endmodule // tb
`default_nettype wire

// ---- inc/trace_pkg.sv ----
// constants and types for the bus trace fault capture block
// How it works
// - write into C000-FFFF during run is fault
// - opcode fetch outside C000-FFFF is fault
// - keep last 8192 records, oldest overwritten
// - trigger at writer or preceding instruction
// - no fault by return: buffer empty
// - new set-up cancels previous set-up
// - reset/set-up empty buffer; empty errors
// - aux byte: probes, read line, start flag
// - start flag only on first cycle
// - 16-bit address match, optional start qualifier
// - data/aux match with don't-care bits
// - one criterion per field, all must match
// - find nth match, negative searches backward
// - found: offset moves to containing instruction
// - buffer end: not found, offset restored
// - offset load; same value reports error
// - record holds address, data, aux byte
`default_nettype none

package trace_pkg;
  localparam int DEPTH = 8192;
  localparam int PTR_W = 13;
  localparam int N_W = 15;
  localparam logic [PTR_W:0] FILL_FULL = 14'h2000;
  localparam logic [15:0] PROG_LO = 16'hC000;
  localparam logic [15:0] PROG_HI = 16'hFFFF;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_ACRIT = 8'h0C;
  localparam logic [7:0] OFS_DCRIT = 8'h10;
  localparam logic [7:0] OFS_SEARCH = 8'h14;
  localparam int CTRL_ARM = 0;
  localparam int ST_ARMED = 0;
  localparam int ST_TRIG = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_FOUND = 4;
  localparam int ST_MISS = 5;
  localparam int ST_ERR_EMPTY = 6;
  localparam int ST_ERR_SAME = 7;
  localparam int ST_FILL_LSB = 16;
  localparam int SR_N_LSB = 16;
  localparam logic [N_W-1:0] N_DEFAULT = 15'h0001;
  localparam logic [PTR_W-1:0] PTR_RST = 13'h0000;
  localparam logic [31:0] CRIT_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADV = 3'b001,
    S_READ = 3'b010,
    S_CMP = 3'b011,
    S_BACK = 3'b100,
    S_BWAIT = 3'b101
  } srch_state_t;
endpackage

`default_nettype wire

// ---- rtl/bus_trace_fault_capture.sv ----
// fault trace capture buffer with search engine behind an AHB-Lite slave
`default_nettype none

module bus_trace_fault_capture
  import trace_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic bus_strobe,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_data,
  input wire logic bus_read,
  input wire logic instruction_start_flag,
  input wire logic [5:0] user_probe_inputs,
  input wire logic user_running,
  output logic nmi
);
  logic wr_q;
  logic [7:0] addr_q;
  logic rd_req;
  logic in_map;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic setup;
  logic search_go;
  logic load_go;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] last_start;
  logic [PTR_W-1:0] trig_ptr;
  logic [PTR_W-1:0] pos;
  logic [PTR_W-1:0] cur;
  logic [PTR_W-1:0] saved_pos;
  logic [PTR_W-1:0] oldest;
  logic [PTR_W-1:0] lpos;
  logic [PTR_W-1:0] ltrig;
  logic [PTR_W-1:0] lcur;
  logic [PTR_W:0] fill;
  logic [PTR_W:0] diff;
  logic [PTR_W:0] remain;
  logic [N_W-1:0] offset_now;
  logic [N_W-1:0] load_val;
  logic [N_W-1:0] n_eff;
  logic [N_W-1:0] n_abs;
  logic [N_W-1:0] n_reg;
  logic [15:0] tgt;
  logic armed;
  logic triggered;
  logic run_q;
  logic capturing;
  logic in_prog;
  logic write_fault;
  logic fetch_fault;
  logic fault;
  logic [31:0] mem [DEPTH];
  logic [31:0] rec_in;
  logic [31:0] rd_data;
  logic [15:0] addr_val;
  logic [15:0] addr_care;
  logic [31:0] dcrit;
  logic [3:0] en;
  srch_state_t state;
  logic back;
  logic found;
  logic miss;
  logic err_empty;
  logic err_same;
  logic hit;
  logic at_end;

  // bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign in_map = haddr[31:8] == 24'h000000;
  assign rd_req = hsel && htrans[1] && hready && !hwrite;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q <= hsel && htrans[1] && hready && hwrite && in_map;
      addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      hrdata <= 32'h0000_0000;
    else if (rd_req)
      hrdata <= in_map ? rd_mux : 32'h0000_0000;
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_ARMED] = armed;
    status_word[ST_TRIG] = triggered;
    status_word[ST_EMPTY] = fill == '0;
    status_word[ST_BUSY] = state != S_IDLE;
    status_word[ST_FOUND] = found;
    status_word[ST_MISS] = miss;
    status_word[ST_ERR_EMPTY] = err_empty;
    status_word[ST_ERR_SAME] = err_same;
    status_word[ST_FILL_LSB +: PTR_W + 1] = fill;
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: rd_mux[CTRL_ARM] = armed;
      OFS_STATUS: rd_mux = status_word;
      OFS_OFFSET: rd_mux = {{17{offset_now[N_W-1]}}, offset_now};
      OFS_ACRIT: rd_mux = {addr_care, addr_val};
      OFS_DCRIT: rd_mux = dcrit;
      OFS_SEARCH: rd_mux = {1'b0, n_reg, 12'h000, en};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // data-phase write strobes
  assign setup = wr_q && addr_q == OFS_CTRL && hwdata[CTRL_ARM];
  assign search_go = wr_q && addr_q == OFS_SEARCH && state == S_IDLE;
  assign load_go = wr_q && addr_q == OFS_OFFSET && state == S_IDLE;
  assign load_val = hwdata[N_W-1:0];

  // criteria stay frozen while a search runs
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_val <= CRIT_RST[15:0];
      addr_care <= CRIT_RST[31:16];
      dcrit <= CRIT_RST;
      en <= CRIT_RST[3:0];
      n_reg <= N_DEFAULT;
    end
    else if (wr_q && state == S_IDLE)
    begin
      if (addr_q == OFS_ACRIT)
      begin
        addr_val <= hwdata[15:0];
        addr_care <= hwdata[31:16];
      end
      if (addr_q == OFS_DCRIT)
        dcrit <= hwdata;
      if (addr_q == OFS_SEARCH)
      begin
        en <= hwdata[3:0];
        n_reg <= n_eff;
      end
    end
  end

  // fault detection on the observed bus
  assign capturing = armed && user_running;
  assign in_prog = bus_addr >= PROG_LO && bus_addr <= PROG_HI;
  assign write_fault = !bus_read && in_prog;
  assign fetch_fault = instruction_start_flag && !in_prog;
  assign fault = capturing && bus_strobe && (write_fault || fetch_fault);
  // aux byte: probes 7..2, read line 1, start flag 0
  assign rec_in = {bus_addr, bus_data, user_probe_inputs, bus_read, instruction_start_flag};

  always_ff @(posedge core_clk)
  begin
    if (capturing && bus_strobe)
      mem[wr_ptr] <= rec_in;
    rd_data <= mem[cur];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= PTR_RST;
      fill <= '0;
      armed <= 1'b0;
      triggered <= 1'b0;
      last_start <= PTR_RST;
      trig_ptr <= PTR_RST;
      run_q <= 1'b0;
    end
    else
    begin
      run_q <= user_running;
      if (setup)
      begin
        wr_ptr <= PTR_RST;
        fill <= '0;
        armed <= 1'b1;
        triggered <= 1'b0;
        trig_ptr <= PTR_RST;
        last_start <= PTR_RST;
      end
      else if (capturing && bus_strobe)
      begin
        wr_ptr <= wr_ptr + 13'h0001;
        if (fill != FILL_FULL)
          fill <= fill + 14'h0001;
        if (instruction_start_flag)
          last_start <= wr_ptr;
        if (fault)
        begin
          armed <= 1'b0;
          triggered <= 1'b1;
          trig_ptr <= last_start;
        end
      end
      else if (run_q && !user_running && armed)
      begin
        armed <= 1'b0;
        fill <= '0;
      end
    end
  end

  // held until the monitor has taken control back
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      nmi <= 1'b0;
    else if (fault)
      nmi <= 1'b1;
    else if (setup || !user_running)
      nmi <= 1'b0;
  end

  // logical positions count from the oldest retained record
  assign oldest = wr_ptr - fill[PTR_W-1:0];
  assign lpos = pos - oldest;
  assign ltrig = trig_ptr - oldest;
  assign lcur = cur - oldest;
  assign diff = {1'b0, lpos} - {1'b0, ltrig};
  assign offset_now = {diff[PTR_W], diff};
  assign tgt = {3'b000, ltrig} + {load_val[N_W-1], load_val};
  assign at_end = back ? lcur == PTR_RST : {1'b0, lcur} == fill - 14'h0001;

  always_comb
  begin
    n_eff = hwdata[SR_N_LSB +: N_W];
    if (n_eff == '0)
      n_eff = N_DEFAULT;
    n_abs = n_eff[N_W-1] ? N_W'(-n_eff) : n_eff;
  end

  record_match u_match (
    .rec(rd_data),
    .addr_val(addr_val),
    .addr_care(addr_care),
    .dcrit(dcrit),
    .en(en),
    .hit(hit)
  );

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= S_IDLE;
      cur <= PTR_RST;
      pos <= PTR_RST;
      saved_pos <= PTR_RST;
      remain <= '0;
      back <= 1'b0;
      found <= 1'b0;
      miss <= 1'b0;
      err_empty <= 1'b0;
      err_same <= 1'b0;
    end
    else if (setup)
    begin
      state <= S_IDLE;
      pos <= PTR_RST;
      found <= 1'b0;
      miss <= 1'b0;
      err_empty <= 1'b0;
      err_same <= 1'b0;
    end
    else if (fault)
      pos <= last_start;
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (search_go || load_go)
          begin
            found <= 1'b0;
            miss <= 1'b0;
            err_empty <= 1'b0;
            err_same <= 1'b0;
            if (fill == '0)
              err_empty <= 1'b1;
            else if (search_go)
            begin
              back <= n_eff[N_W-1];
              remain <= n_abs[PTR_W:0];
              cur <= pos;
              saved_pos <= pos;
              state <= S_ADV;
            end
            else if (load_val == offset_now)
              err_same <= 1'b1;
            else if (tgt[15] || tgt >= {2'b00, fill})
              miss <= 1'b1;
            else
              pos <= oldest + tgt[PTR_W-1:0];
          end
        end
        S_ADV:
        begin
          if (at_end)
          begin
            miss <= 1'b1;
            pos <= saved_pos;
            state <= S_IDLE;
          end
          else
          begin
            cur <= back ? cur - 13'h0001 : cur + 13'h0001;
            state <= S_READ;
          end
        end
        S_READ: state <= S_CMP;
        S_CMP:
        begin
          if (hit && remain == 14'h0001)
            state <= S_BACK;
          else
          begin
            if (hit)
              remain <= remain - 14'h0001;
            state <= S_ADV;
          end
        end
        S_BACK:
        begin
          // walk back to the opcode fetch of the matching instruction
          if (rd_data[0] || lcur == PTR_RST)
          begin
            pos <= cur;
            found <= 1'b1;
            state <= S_IDLE;
          end
          else
          begin
            cur <= cur - 13'h0001;
            state <= S_BWAIT;
          end
        end
        S_BWAIT: state <= S_BACK;
        default: state <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_write_fault;
    capturing && bus_strobe && !bus_read && bus_addr >= PROG_LO |=> nmi && !armed;
  endproperty
  a_write_fault: assert property (p_write_fault)
    else $error("write into program region raised no nmi");

  property p_fetch_fault;
    capturing && bus_strobe && instruction_start_flag && bus_addr < PROG_LO
      |=> nmi && triggered;
  endproperty
  a_fetch_fault: assert property (p_fetch_fault)
    else $error("fetch outside program region raised no nmi");

  property p_fault_offset;
    fault |=> pos == $past(last_start) && trig_ptr == pos && offset_now == '0;
  endproperty
  a_fault_offset: assert property (p_fault_offset)
    else $error("trigger offset not at faulting instruction");

  property p_return_empty;
    armed && run_q && !user_running && !setup |=> fill == '0 && !armed && !nmi;
  endproperty
  a_return_empty: assert property (p_return_empty)
    else $error("buffer not empty after run without fault");

  property p_setup_clear;
    setup |=> fill == '0 && armed && !triggered && !nmi && state == S_IDLE && offset_now == '0;
  endproperty
  a_setup_clear: assert property (p_setup_clear)
    else $error("set-up did not clear buffer and arm");

  property p_fill_wrap;
    capturing && bus_strobe && fill == FILL_FULL && !setup
      |=> fill == FILL_FULL && wr_ptr == PTR_W'($past(wr_ptr) + 13'h0001);
  endproperty
  a_fill_wrap: assert property (p_fill_wrap)
    else $error("full buffer did not overwrite oldest record");

  property p_empty_err;
    search_go && fill == '0 && !setup && !fault |=> err_empty && state == S_IDLE;
  endproperty
  a_empty_err: assert property (p_empty_err)
    else $error("search on empty buffer not refused");

  property p_miss_restore;
    state == S_ADV && at_end && !setup
      |=> miss && !found && pos == $past(saved_pos) && state == S_IDLE;
  endproperty
  a_miss_restore: assert property (p_miss_restore)
    else $error("search end did not restore offset");

  property p_same_err;
    load_go && fill != '0 && load_val == offset_now && !setup && !fault
      |=> err_same && $stable(pos);
  endproperty
  a_same_err: assert property (p_same_err)
    else $error("offset load to same value not refused");

endmodule // bus_trace_fault_capture

`default_nettype wire

// ---- rtl/record_match.sv ----
// compares one captured record against the search criteria
`default_nettype none

module record_match
  import trace_pkg::*;
(
  input wire logic [31:0] rec,
  input wire logic [15:0] addr_val,
  input wire logic [15:0] addr_care,
  input wire logic [31:0] dcrit,
  input wire logic [3:0] en,
  output logic hit
);
  logic addr_ok;
  logic data_ok;
  logic aux_ok;

  // care bit 0 means don't-care; all ones gives an exact value
  assign addr_ok = !(en[0] || en[1]) || ((rec[31:16] ^ addr_val) & addr_care) == 16'h0000;
  assign data_ok = !en[2] || ((rec[15:8] ^ dcrit[7:0]) & dcrit[15:8]) == 8'h00;
  assign aux_ok = !en[3] || ((rec[7:0] ^ dcrit[23:16]) & dcrit[31:24]) == 8'h00;
  // instruction-qualified address needs the start flag set
  assign hit = addr_ok && data_ok && aux_ok && (!en[1] || rec[0]);

endmodule // record_match

`default_nettype wire
